// ===== core/key_wakeup_release.sv
module key_wakeup_release (
  // Clock, reset, enable
  input  wire logic              core_clk_i,
  input  wire logic              nrst_i,
  input  wire logic              ce_i,
  // Register port
  input  wire kwu_pkg::reg_req_t reg_req_i,
  output logic             [7:0] rdata_o,
  // Release pins
  input  wire logic              primary_release_i,
  input  wire logic        [3:0] key_wake_input_i,
  // Power state
  output logic                   standby_o,
  output logic                   warmup_o,
  output logic                   release_req_o
);
  logic [3:0]            enable;
  logic                  relm;
  kwu_pkg::power_state_t state;
  logic [7:0]            wcount;
  logic                  prim_prev;
  logic [7:0]            rdata;
  logic [3:0]            next_enable;
  logic                  next_relm;
  kwu_pkg::power_state_t next_state;
  logic [7:0]            next_wcount;
  logic                  next_prim_prev;
  logic [7:0]            next_rdata;
  logic [4:0]            pins_sync;
  logic                  prim;
  logic [3:0]            keys;
  logic                  key_low;
  logic                  prim_cond;
  logic                  release_req;
  logic                  entry_write;
  logic [7:0]            warm_age;
  logic [7:0]            next_warm_age;

  // Dedicated detector path for release inputs
  kwu_sync u_sync (
    .core_clk_i (core_clk_i),
    .nrst_i     (nrst_i),
    .ce_i       (ce_i),
    .raw_i      ({key_wake_input_i, primary_release_i}),
    .sync_o     (pins_sync)
  );

  assign prim = pins_sync[0];
  assign keys = pins_sync[4:1];

  // Keys only release standby in level mode
  assign key_low     = relm && (|(enable & ~keys));
  // Primary pin always active, no enable
  assign prim_cond   = relm ? prim : (prim && !prim_prev);
  assign release_req = prim_cond || key_low;

  assign entry_write = reg_req_i.wr && (reg_req_i.addr == kwu_pkg::system_control_one_addr);

  // Register file
  always_comb begin
    next_enable = enable;
    next_relm   = relm;
    next_rdata  = 8'h00;
    if (reg_req_i.wr && reg_req_i.addr == kwu_pkg::key_wake_enable_addr) begin
      next_enable = reg_req_i.wdata[kwu_pkg::enable_lsb +: 4];
    end
    if (entry_write) begin
      next_relm = reg_req_i.wdata[kwu_pkg::sc1_relm_bit];
    end
    // Enable register is write only and reads zero
    if (reg_req_i.rd && reg_req_i.addr == kwu_pkg::system_control_one_addr) begin
      next_rdata[kwu_pkg::sc1_relm_bit] = relm;
      next_rdata[1:0] = {state == kwu_pkg::st_warmup, state == kwu_pkg::st_standby};
    end
  end

  // Power state machine
  always_comb begin
    next_state     = state;
    next_wcount    = wcount;
    next_prim_prev = prim;
    // Assertion helper: age of the current warm-up
    next_warm_age  = (state == kwu_pkg::st_warmup) ? (warm_age + 8'h01) : 8'h00;
    unique case (state)
      kwu_pkg::st_run: begin
        if (entry_write && reg_req_i.wdata[kwu_pkg::sc1_stop_bit]) begin
          // Level already at release: abort into warm-up
          if (prim || (|(enable & ~keys))) begin
            next_state  = kwu_pkg::st_warmup;
            next_wcount = 8'h00;
          end else begin
            next_state = kwu_pkg::st_standby;
          end
        end
      end
      kwu_pkg::st_standby: begin
        if (release_req) begin
          next_state  = kwu_pkg::st_warmup;
          next_wcount = 8'h00;
        end
      end
      kwu_pkg::st_warmup: begin
        next_wcount = wcount + 8'h01;
        if (wcount == 8'(kwu_pkg::warmup_cycles - 1)) begin
          next_state = kwu_pkg::st_run;
        end
      end
    endcase
  end

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      enable    <= kwu_pkg::enable_reset;
      relm      <= kwu_pkg::relm_reset;
      state     <= kwu_pkg::st_run;
      wcount    <= 8'h00;
      prim_prev <= 1'b0;
      rdata     <= 8'h00;
      warm_age  <= 8'h00;
    end else if (ce_i) begin
      enable    <= next_enable;
      relm      <= next_relm;
      state     <= next_state;
      wcount    <= next_wcount;
      prim_prev <= next_prim_prev;
      rdata     <= next_rdata;
      warm_age  <= next_warm_age;
    end
  end

  assign rdata_o       = rdata;
  assign standby_o     = (state == kwu_pkg::st_standby);
  assign warmup_o      = (state == kwu_pkg::st_warmup);
  assign release_req_o = release_req;

  a_key_level_wake : assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    (ce_i && standby_o && relm && |(enable & ~keys)) |=> warmup_o)
    else $error("enabled low key did not wake");

  a_edge_ignores_keys : assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    (ce_i && standby_o && !relm && !(prim && !prim_prev)) |=> standby_o)
    else $error("edge mode woke without rising edge");

  a_abort_entry : assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    (ce_i && state == kwu_pkg::st_run && entry_write && reg_req_i.wdata[kwu_pkg::sc1_stop_bit]
     && prim) |=> warmup_o)
    else $error("entry not aborted");

  a_key_abort : assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    (ce_i && state == kwu_pkg::st_run && entry_write && reg_req_i.wdata[kwu_pkg::sc1_stop_bit]
     && |(enable & ~keys)) |=> warmup_o)
    else $error("entry with enabled low key not aborted");

  a_warmup_holds : assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    (ce_i && warmup_o && warm_age < 8'(kwu_pkg::warmup_cycles - 1)) |=> warmup_o)
    else $error("warm-up ended early");

  a_warmup_ends : assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    (ce_i && warmup_o && warm_age == 8'(kwu_pkg::warmup_cycles - 1)) |=> !warmup_o)
    else $error("warm-up ran too long");

  a_enable_reset : assert property (@(posedge core_clk_i)
    $rose(nrst_i) |-> enable == kwu_pkg::enable_reset)
    else $error("enable not cleared by reset");
endmodule : key_wakeup_release

// ===== core/kwu_sync.sv
module kwu_sync (
  // Clock and reset
  input  wire logic       core_clk_i,
  input  wire logic       nrst_i,
  input  wire logic       ce_i,
  // Raw and synchronised levels
  input  wire logic [4:0] raw_i,
  output logic      [4:0] sync_o
);
  logic [4:0] stage1;
  logic [4:0] stage2;
  logic [4:0] next_stage1;
  logic [4:0] next_stage2;

  // Idle pin levels: primary low, keys high
  always_comb begin
    next_stage1 = stage1;
    next_stage2 = stage2;
    if (ce_i) begin
      next_stage1 = raw_i;
      next_stage2 = stage1;
    end
  end

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      stage1 <= 5'h1e;
      stage2 <= 5'h1e;
    end else begin
      stage1 <= next_stage1;
      stage2 <= next_stage2;
    end
  end

  assign sync_o = stage2;
endmodule : kwu_sync

// ===== shared/kwu_pkg.sv
// Summary of operation
// - Bits 7..4 of key wake enable gate key wake inputs five..two.
// - Key wake enable is write only, resets to zero, low nibble undefined.
// - Level release mode leaves standby on low of any enabled key input.
// - Primary pin releases on high in level mode, rising edge in edge mode.
// - Release condition at entry aborts standby and starts warm-up at once.
// - Primary pin has no enable; its release function is always active.
// - Key wake detector uses its own input path, apart from port input.
// - Writing the standby setting into system control one enters standby.
package kwu_pkg;
  localparam logic [11:0] key_wake_enable_addr    = 12'hf9a;
  localparam logic [11:0] system_control_one_addr = 12'hf9b;
  localparam int          enable_lsb              = 4;
  localparam logic [3:0]  enable_reset            = 4'h0;
  localparam int          sc1_stop_bit            = 7;
  localparam int          sc1_relm_bit            = 6;
  localparam logic        relm_reset              = 1'b0;
  localparam int          warmup_ns               = 1000;
  localparam int          clk_period_ns           = 100;
  localparam int          warmup_cycles           = (warmup_ns + clk_period_ns - 1) / clk_period_ns;

  typedef enum logic [1:0] {
    st_run,
    st_standby,
    st_warmup
  } power_state_t;

  typedef struct packed {
    logic [11:0] addr;
    logic [7:0]  wdata;
    logic        wr;
    logic        rd;
  } reg_req_t;
endpackage : kwu_pkg

// ===== sim/key_wake_source.sv
module key_wake_source (
  // Stimulus from the bench
  input  wire logic       primary_i,
  input  wire logic [3:0] press_i,
  // Pins toward the block
  output logic            primary_o,
  output logic      [3:0] key_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // Released keys rest at the pull-up level
  // Keys act only as digital inputs toward the block, never analog
  assign key_o     = ~press_i;
  assign primary_o = primary_i;
endmodule : key_wake_source

// ===== sim/key_wakeup_release_tb_top.sv
module key_wakeup_release_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  `define check_eq(nm, e, g) begin comparisons++; if ((g) !== (e)) begin fails++; \
    $display("wrong value %s expected %h seen %h", nm, e, g); end end
  localparam logic [11:0] sc = kwu_pkg::system_control_one_addr;
  localparam logic [11:0] ke = kwu_pkg::key_wake_enable_addr;
  logic              core_clk_i = 1'b0;
  logic              nrst_i     = 1'b0;
  kwu_pkg::reg_req_t req        = '0;
  logic        [7:0] rdata;
  logic              prim       = 1'b0;
  logic        [3:0] press      = 4'h0;
  logic        [3:0] keys;
  logic              prim_pin;
  logic              pend       = 1'b0;
  logic              ce         = 1'b1;
  logic              standby;
  logic              warmup;
  logic              rel_req;
  logic       [10:0] expq[$];
  logic       [10:0] e;
  int                fails       = 0;
  int                comparisons = 0;
  int                seed        = 11;

  key_wake_source u_src (.primary_i(prim), .press_i(press), .primary_o(prim_pin), .key_o(keys));
  key_wakeup_release u_dut (
    .core_clk_i(core_clk_i), .nrst_i(nrst_i), .ce_i(ce), .reg_req_i(req), .rdata_o(rdata),
    .primary_release_i(prim_pin), .key_wake_input_i(keys),
    .standby_o(standby), .warmup_o(warmup), .release_req_o(rel_req)
  );

  initial begin
    forever #50 core_clk_i = ~core_clk_i;
  end

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge core_clk_i);
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [7:0] x, input logic r);
    expq.push_back({r, (a == sc) ? x[1:0] : 2'b00, x});
    req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge core_clk_i);
  endtask : rd

  task automatic wt(input int n);
    req <= '0;
    repeat (n) @(posedge core_clk_i);
  endtask : wt

  task automatic end_sim();
    $display("fails %0d comparisons %0d", fails, comparisons);
    if (fails == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : end_sim

  // Read data stand in the cycle after the strobe
  always @(posedge core_clk_i) pend <= req.rd;
  always @(negedge core_clk_i) begin
    if (pend) begin
      e = expq.pop_front();
      `check_eq("rdata_o", e[7:0], rdata)
      `check_eq("state", e[9:8], {warmup, standby})
      `check_eq("release_req_o", e[10], rel_req)
    end
  end

  initial begin
    repeat (6) @(posedge core_clk_i);
    nrst_i <= 1'b1;
    rd(sc, 8'h00, 1'b0);
    rd(ke, 8'h00, 1'b0);
    rd(12'h123, 8'h00, 1'b0);
    for (int k = 0; k < 4; k++) begin
      wr(ke, {4'h1 << k, 4'($random(seed))});
      `check_eq("key_wake_input", 4'hf, keys)
      wr(sc, 8'hc0);
      rd(sc, 8'h41, 1'b0);
      press <= 4'h1 << ((k + 1) % 4);
      wt(5);
      rd(sc, 8'h41, 1'b0);
      press <= 4'h1 << k;
      wt(5);
      rd(sc, 8'h42, 1'b1);
      press <= 4'h0;
      wt(15);
    end
    // Edge mode: primary rising edge
    wr(sc, 8'h80);
    rd(sc, 8'h01, 1'b0);
    prim <= 1'b1;
    wt(5);
    rd(sc, 8'h02, 1'b0);
    prim <= 1'b0;
    wt(15);
    // Entry with a release condition already present
    prim <= 1'b1;
    wt(3);
    wr(sc, 8'h80);
    wt(2);
    rd(sc, 8'h02, 1'b0);
    prim <= 1'b0;
    press <= 4'h8;
    wt(15);
    wr(sc, 8'hc0);
    wt(2);
    rd(sc, 8'h42, 1'b1);
    press <= 4'h0;
    wt(15);
    // Clock enable low freezes a running warm-up
    wr(sc, 8'h80);
    prim <= 1'b1;
    wt(4);
    ce <= 1'b0;
    wt(20);
    ce <= 1'b1;
    rd(sc, 8'h02, 1'b0);
    prim <= 1'b0;
    wt(15);
    // Mid-run reset clears the key enables
    wr(ke, 8'hf0);
    nrst_i <= 1'b0;
    wt(2);
    nrst_i <= 1'b1;
    press <= 4'hf;
    wt(3);
    wr(sc, 8'hc0);
    rd(sc, 8'h41, 1'b0);
    prim <= 1'b1;
    wt(5);
    rd(sc, 8'h42, 1'b1);
    prim <= 1'b0;
    press <= 4'h0;
    wt(15);
    end_sim();
  end

  initial begin
    #(2000 * 100);
    fails++;
    end_sim();
  end
endmodule : key_wakeup_release_tb_top
